/* File: hw/lsm_defs.vh */
// constants for the lvds input skew test multiplexer
`ifndef LSM_DEFS_VH
`define LSM_DEFS_VH
`define LSM_REG_SELECT 8'h18
`define LSM_REG_TDIO 8'h19
`define LSM_SELECT_RESET 8'h00
`define LSM_BIT_ENABLE 6
`define LSM_ADR_HI 5
`define LSM_ADR_LO 1
`define LSM_BIT_MSEL 0
`define LSM_ADR_W 5
`define LSM_ADR_CLK 5'h10
`define LSM_DATA_W 16
`endif

/* File: hw/lsm_skew_mux.v */
// lvds input skew test multiplexer with its spi-written select register
// Contract
// RL1: host clears test pin data io enable at 0x19 before enabling mux.
// RL2: enable bit set drives selected lvds input onto test output pair.
// RL3: pair address chooses two neighbouring lvds inputs, data clock included; address 01111 here pairs b msb with a quiet zero.
// RL4: member select zero shows first signal of pair, normal polarity.
// RL5: member select one shows second signal of pair, inverted.
// RL6: writing 0x60 enables, address 10000, shows port b msb.
// RL7: writing 0x61 shows data clock input inverted at same address.
// RL8: host drives alternating codes on data ports during measurement; the bench holds run low while measuring, so its data stay still.
// RL9: compare only neighbours of one address and like edges.
// RL10: host keeps enable bit zero during normal conversion.
// RL11: enable zero leaves test output undriven regardless of other fields.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_defs.vh"
module lsm_skew_mux #(
  parameter DATA_W = `LSM_DATA_W
) (
  input wire CLK_SYS,
  input wire RST_N,
  input wire REG_WR,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire LVDS_DATA_CLOCK_IN,
  input wire [DATA_W-1:0] LVDS_PORT_A_DATA,
  input wire [DATA_W-1:0] LVDS_PORT_B_DATA,
  input wire TEST_PIN_DATA_IO_ENABLE,
  output reg TEST_OUTPUT_PAIR_P,
  output reg TEST_OUTPUT_PAIR_N,
  output reg TEST_OUTPUT_PAIR_OE_N
);
  localparam NIN = 2 * DATA_W + 1;
  reg [7:0] select_r;
  wire [NIN-1:0] pins_s;
  wire skew_mux_enable;
  wire [`LSM_ADR_W-1:0] skew_mux_pair_address;
  wire skew_mux_member_select;
  reg first_nxt;
  reg second_nxt;
  reg out_nxt;

  // inputs ordered: a[0..], clock, b[0..]; neighbours chain through the clock
  lsm_sync3 #(.W(NIN)) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .d({LVDS_PORT_B_DATA, LVDS_DATA_CLOCK_IN, LVDS_PORT_A_DATA}),
    .q(pins_s)
  );

  assign skew_mux_enable = select_r[`LSM_BIT_ENABLE];
  assign skew_mux_pair_address = select_r[`LSM_ADR_HI:`LSM_ADR_LO];
  assign skew_mux_member_select = select_r[`LSM_BIT_MSEL];

  // chain regions, one-hot; the clock sits between the two ports
  localparam RGN_B = 3'b001;
  localparam RGN_CLK = 3'b010;
  localparam RGN_A = 3'b100;

  // write and read decode kept apart so each path has one owner
  wire wr_select;
  wire rd_select;
  integer first_i;
  integer second_i;

  assign wr_select = REG_WR && (REG_ADDR == `LSM_REG_SELECT);
  assign rd_select = (REG_ADDR == `LSM_REG_SELECT);

  // which part of the chain an address falls in
  function [2:0] region_of;
    input [`LSM_ADR_W-1:0] adr;
    begin
      if (adr == `LSM_ADR_CLK) begin
        region_of = RGN_CLK;
      end else if (adr < `LSM_ADR_CLK) begin
        region_of = RGN_B;
      end else begin
        region_of = RGN_A;
      end
    end
  endfunction

  // index of first pair member; address 10000 pairs b msb with the clock
  function integer first_idx;
    input [`LSM_ADR_W-1:0] adr;
    begin
      case (region_of(adr))
        RGN_CLK: begin
          first_idx = NIN - 1;
        end
        RGN_B: begin
          first_idx = DATA_W + 1 + adr;
        end
        RGN_A: begin
          first_idx = adr - `LSM_ADR_CLK - 1;
        end
        default: begin
          first_idx = NIN;
        end
      endcase
    end
  endfunction

  // index of second pair member, the neighbour one step up the chain; the clock at address 10000
  function integer second_idx;
    input [`LSM_ADR_W-1:0] adr;
    begin
      case (region_of(adr))
        RGN_CLK: begin
          second_idx = DATA_W;
        end
        RGN_B: begin
          second_idx = DATA_W + 2 + adr;
        end
        RGN_A: begin
          second_idx = adr - `LSM_ADR_CLK;
        end
        default: begin
          second_idx = NIN;
        end
      endcase
    end
  endfunction

  // indices past the chain end give a quiet zero instead of an x
  function in_chain;
    input integer idx;
    begin
      in_chain = (idx >= 0) && (idx < NIN);
    end
  endfunction

  function pick;
    input [NIN-1:0] pins;
    input integer idx;
    begin
      pick = 1'b0;
      if (in_chain(idx)) begin
        pick = pins[idx];
      end
    end
  endfunction

  always @* begin
    first_i = first_idx(skew_mux_pair_address);
    second_i = second_idx(skew_mux_pair_address);
    first_nxt = pick(pins_s, first_i); // RL3
    second_nxt = pick(pins_s, second_i); // RL3
    // first member straight, second member inverted
    out_nxt = skew_mux_member_select ? ~second_nxt : first_nxt; // RL4 RL5
  end

  // register write: 0x60 / 0x61 decode through the same field layout
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      select_r <= `LSM_SELECT_RESET;
    end else if (wr_select) begin
      select_r <= {1'b0, REG_WDATA[`LSM_BIT_ENABLE:0]}; // RL6 RL7
    end
  end

  // read data registered; follows the address one cycle late
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (rd_select) begin
      REG_RDATA <= select_r;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // no check of the io enable: keeping it clear is the host's duty
  // one process per pin so each output stays a plain flip-flop
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TEST_OUTPUT_PAIR_P <= 1'b0;
    end else if (skew_mux_enable) begin
      TEST_OUTPUT_PAIR_P <= out_nxt; // RL2
    end else begin
      TEST_OUTPUT_PAIR_P <= 1'b0; // RL11
    end
  end

  // complement only while driven; both low when released
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TEST_OUTPUT_PAIR_N <= 1'b0;
    end else if (skew_mux_enable) begin
      TEST_OUTPUT_PAIR_N <= ~out_nxt; // RL2
    end else begin
      TEST_OUTPUT_PAIR_N <= 1'b0; // RL11
    end
  end

  // enable low while driving; same edge as the data so no glitch leaks out
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TEST_OUTPUT_PAIR_OE_N <= 1'b1;
    end else if (skew_mux_enable) begin
      TEST_OUTPUT_PAIR_OE_N <= 1'b0; // RL2
    end else begin
      TEST_OUTPUT_PAIR_OE_N <= 1'b1; // RL11
    end
  end

  // limitation: the pair shows pins after the synchroniser, so skew seen
  // here is quantised to the system clock, not the analogue timing
endmodule // lsm_skew_mux
`default_nettype wire

/* File: hw/lsm_sync3.v */
// three-stage synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module lsm_sync3 #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // per bit: keep old value until the two later stages agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // lsm_sync3
`default_nettype wire

/* File: sim/lsm_host_model.sv */
// host model: lvds clock and alternating data
`timescale 1ns/1ps
`default_nettype none
module lsm_host_model (
  input wire logic run,
  output logic dck,
  output logic [15:0] a,
  output logic [15:0] b
);
  initial begin
    dck = 1'b0;
    #7;
    forever #160 if (run) dck = ~dck; // still while run is low, which covers each measurement
  end
  assign b = dck ? 16'haaaa : 16'h5555;
  assign a = b;
endmodule // lsm_host_model
`default_nettype wire

/* File: sim/lsm_skew_mux_sva.sv */
// output checks for the skew test mux
`timescale 1ns/1ps
`default_nettype none
module lsm_skew_mux_sva (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic LVDS_DATA_CLOCK_IN,
  input wire logic TEST_OUTPUT_PAIR_P,
  input wire logic TEST_OUTPUT_PAIR_N,
  input wire logic TEST_OUTPUT_PAIR_OE_N
);
  wire logic w = REG_WR && REG_ADDR == 8'h18;
  wire logic p = TEST_OUTPUT_PAIR_P;
  wire logic c = LVDS_DATA_CLOCK_IN;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  property p_on; w && REG_WDATA[6] |-> ##2 !TEST_OUTPUT_PAIR_OE_N && p != TEST_OUTPUT_PAIR_N; endproperty
  a_on: assert property (p_on) else $error("not driven");
  property p_off; w && !REG_WDATA[6] |-> ##2 TEST_OUTPUT_PAIR_OE_N && !p && !TEST_OUTPUT_PAIR_N; endproperty
  a_off: assert property (p_off) else $error("driven while off");
  property p_clk; w && REG_WDATA == 8'h61 ##1 (!REG_WR && $stable(c))[*6] |-> p == !c; endproperty
  a_clk: assert property (p_clk) else $error("clock not inverted");
  property p_pair; !TEST_OUTPUT_PAIR_OE_N |-> p != TEST_OUTPUT_PAIR_N; endproperty
  a_pair: assert property (p_pair) else $error("pair not complementary");
  property p_idle; TEST_OUTPUT_PAIR_OE_N |-> !p && !TEST_OUTPUT_PAIR_N; endproperty
  a_idle: assert property (p_idle) else $error("released pair not quiet");
  property p_rd; w && REG_WDATA == 8'h60 ##1 REG_ADDR == 8'h18 |=> REG_RDATA == 8'h60 && !TEST_OUTPUT_PAIR_OE_N; endproperty
  a_rd: assert property (p_rd) else $error("enable and address not applied");
endmodule // lsm_skew_mux_sva
bind lsm_skew_mux lsm_skew_mux_sva u_sva (.*);
`default_nettype wire

/* File: sim/lvds_input_skew_test_mux_test.sv */
// bench for the skew test mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin error_cnt++; $display("CHECK FAILED %0t %h %h", $time, x, y); end end
module lvds_input_skew_test_mux_test;
  logic ck = 1'b0, rn = 1'b0, we = 1'b0, run = 1'b0, c, p, n, oe, e;
  logic [7:0] ad = 8'h18, wd = 8'h00, rd, v;
  logic [7:0] t [7] = '{8'h20, 8'h60, 8'h61, 8'h42, 8'h43, 8'h62, 8'he3};
  logic [15:0] a, b;
  int error_cnt = 0, n_tests = 0;
  always #20 ck = ~ck;
  lsm_host_model u_host (.run(run), .dck(c), .a(a), .b(b));
  lsm_skew_mux u_dut (.CLK_SYS(ck), .RST_N(rn), .REG_WR(we), .REG_ADDR(ad), .REG_WDATA(wd), .REG_RDATA(rd),
    .LVDS_DATA_CLOCK_IN(c), .LVDS_PORT_A_DATA(a), .LVDS_PORT_B_DATA(b), .TEST_PIN_DATA_IO_ENABLE(1'b0),
    .TEST_OUTPUT_PAIR_P(p), .TEST_OUTPUT_PAIR_N(n), .TEST_OUTPUT_PAIR_OE_N(oe));
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    @(negedge ck);
    we = 1'b1;
    ad = x;
    wd = d;
    @(negedge ck);
    we = 1'b0;
    repeat (8) @(negedge ck);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (3) @(negedge ck);
    `CHK({oe, p, n, rd}, 11'h400)
    rn = 1'b1;
    for (int i = 0; i < 2; i++) begin
      run = 1'b1;
      repeat (4) @(negedge ck);
      run = 1'b0;
      foreach (t[j]) begin
        v = t[j];
        wr(8'h18, v);
        e = (v[5:1] == 5'h10) ? c ^ v[0] : c == (v[1] ^ (v[5:1] > 5'h10));
        `CHK({oe, p, n, rd}, {~v[6], v[6] & e, v[6] & ~e, 1'b0, v[6:0]})
      end
    end
    wr(8'h19, 8'h00);
    `CHK({oe, rd}, 9'h000)
    wr(8'h18, 8'h00);
    `CHK({oe, p, n, rd}, 11'h400)
    give_verdict;
  end
endmodule // lvds_input_skew_test_mux_test
`default_nettype wire
